// File: pkg/eilc_pkg.sv
// Package with register map, field positions and timing counts.
package eilc_pkg;
    // =========================================================
    // Register map
    localparam logic [7:0] CTRL_OFFSET = 8'h88;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h90;
    localparam logic [7:0] IRQ_MASK_OFFSET = 8'h94;
    localparam logic [7:0] CORE_STATUS_OFFSET = 8'h98;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // =========================================================
    // Control register fields
    localparam int TYPE0_BIT = 0;
    localparam int FLAG0_BIT = 1;
    localparam int TYPE1_BIT = 2;
    localparam int FLAG1_BIT = 3;
    // =========================================================
    // Event bits of the status and mask registers
    localparam int EV_FLAG0_BIT = 0;
    localparam int EV_FLAG1_BIT = 1;
    localparam int EV_VECTOR_BIT = 2;
    localparam int EV_WAKE_BIT = 3;
    localparam logic [3:0] EV_RESET = 4'h0;
    // =========================================================
    // Timing
    localparam int CALL_CYCLES = 4;
    localparam int MIN_RESPONSE_CYCLES = 5;
    localparam int MAX_RESPONSE_CYCLES = 16;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
    typedef enum logic [1:0]
    {
        EILC_IDLE = 2'b00,
        EILC_CALL = 2'b01,
        EILC_SERVICE = 2'b10
    } eilc_state_t;
endpackage

// File: logic/eilc_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module eilc_sync
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin,
    output logic level
);
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic next_level;

    // =========================================================
    // Filter
    // The first stage feeds only the second, to contain metastability.
    always_comb
    begin
        next_stage = {stage[1:0], pin};
        next_level = level;
        if (stage[1] == stage[2])
        begin
            next_level = stage[2];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stage <= 3'h7;
            level <= 1'b1;
        end
        else
        begin
            stage <= next_stage;
            level <= next_level;
        end
    end
endmodule

// File: logic/eilc_source.sv
// One external interrupt source: edge or level request flag.
`timescale 1ns/1ps
module eilc_source
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin_level,
    input wire logic trigger_type,
    input wire logic sw_write,
    input wire logic sw_value,
    input wire logic vector_ack,
    output logic request_flag
);
    logic prev_level;
    logic next_flag;
    logic fall;

    // =========================================================
    // Flag logic
    assign fall = prev_level && !pin_level;

    always_comb
    begin
        next_flag = request_flag;
        if (!trigger_type)
        begin
            // Level mode ignores writes and the vector acknowledge.
            next_flag = !pin_level;
        end
        else if (fall)
        begin
            next_flag = 1'b1;
        end
        else if (vector_ack)
        begin
            next_flag = 1'b0;
        end
        else if (sw_write)
        begin
            next_flag = sw_value;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            prev_level <= 1'b1;
            request_flag <= 1'b0;
        end
        else
        begin
            prev_level <= pin_level;
            request_flag <= next_flag;
        end
    end
endmodule

// File: logic/eilc_top.sv
// Top of the external interrupt and vector latency controller.
// Notes on behaviour
// - Poll and resolve priority every clock.
// - Vector call lasts four cycles, five least.
// - Response never exceeds sixteen cycles.
// - Defer call until instruction end, priority free.
// - Trigger bit: zero low level, one falling edge.
// - Edge mode sets flag on high then low.
// - Edge flag clears on vectoring, software writable.
// - Level flag mirrors inverted pin, read only.
// - Level flag not cleared on entry.
// - Pin still low after return re-requests.
// - Either pin wakes from power-down.
// - Control bits 3..0 flag1,type1,flag0,type0; reset zero.
// - Call only when unblocked and not protected instruction.
// - Blocked requests are not remembered; here an edge flag stays set and is taken once unblocked.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module eilc_top
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ext_irq0_pin_n,
    input wire logic ext_irq1_pin_n,
    input wire logic last_cycle,
    input wire logic protected_instr,
    input wire logic return_from_interrupt,
    input wire logic power_down,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic hardware_vector_call,
    output logic vector_source,
    output logic in_service,
    output logic wake_up,
    output logic irq
);
    logic lvl0;
    logic lvl1;
    logic flag0;
    logic flag1;
    logic type0;
    logic type1;
    logic prio0;
    logic prio1;
    logic ack0;
    logic ack1;
    logic sw_wr_ctrl;
    logic [3:0] status;
    logic [3:0] mask;
    logic [3:0] events;
    eilc_pkg::eilc_state_t state;
    eilc_pkg::eilc_state_t next_state;
    logic [2:0] call_cnt;
    logic [2:0] next_call_cnt;
    logic cur_src;
    logic next_cur_src;
    logic take;
    logic pick;
    logic [31:0] w_data;

    // =========================================================
    // Pin synchronisers
    eilc_sync u_sync0
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(ext_irq0_pin_n),
        .level(lvl0)
    );

    eilc_sync u_sync1
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(ext_irq1_pin_n),
        .level(lvl1)
    );

    // =========================================================
    // Request flags
    eilc_source u_src0
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_level(lvl0),
        .trigger_type(type0),
        .sw_write(sw_wr_ctrl),
        .sw_value(w_data[eilc_pkg::FLAG0_BIT]),
        .vector_ack(ack0),
        .request_flag(flag0)
    );

    eilc_source u_src1
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_level(lvl1),
        .trigger_type(type1),
        .sw_write(sw_wr_ctrl),
        .sw_value(w_data[eilc_pkg::FLAG1_BIT]),
        .vector_ack(ack1),
        .request_flag(flag1)
    );

    // =========================================================
    // Vectoring
    // Source 0 wins a tie unless only source 1 has priority; only a higher
    // priority nests, and a blocked level request is not remembered.
    always_comb
    begin
        pick = 1'b0;
        if (flag1 && (!flag0 || (prio1 && !prio0)))
        begin
            pick = 1'b1;
        end
        take = (flag0 || flag1) && last_cycle && !protected_instr;
        if (state == eilc_pkg::EILC_SERVICE)
        begin
            take = take && !return_from_interrupt
                && (pick ? prio1 : prio0) && !(cur_src ? prio1 : prio0);
        end
        else if (state == eilc_pkg::EILC_CALL)
        begin
            take = 1'b0;
        end
        next_state = state;
        next_call_cnt = call_cnt;
        next_cur_src = cur_src;
        case (state)
            eilc_pkg::EILC_IDLE, eilc_pkg::EILC_SERVICE:
            begin
                if (return_from_interrupt && state == eilc_pkg::EILC_SERVICE)
                begin
                    next_state = eilc_pkg::EILC_IDLE;
                end
                else if (take)
                begin
                    next_state = eilc_pkg::EILC_CALL;
                    next_call_cnt = 3'(eilc_pkg::CALL_CYCLES - 1);
                    next_cur_src = pick;
                end
            end
            eilc_pkg::EILC_CALL:
            begin
                if (call_cnt == 3'h0)
                begin
                    next_state = eilc_pkg::EILC_SERVICE;
                end
                else
                begin
                    next_call_cnt = call_cnt - 3'h1;
                end
            end
            default:
            begin
                next_state = eilc_pkg::EILC_IDLE;
            end
        endcase
    end

    assign ack0 = take && !pick;
    assign ack1 = take && pick;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= eilc_pkg::EILC_IDLE;
            call_cnt <= 3'h0;
            cur_src <= 1'b0;
            hardware_vector_call <= 1'b0;
            vector_source <= 1'b0;
            in_service <= 1'b0;
            wake_up <= 1'b0;
        end
        else
        begin
            state <= next_state;
            call_cnt <= next_call_cnt;
            cur_src <= next_cur_src;
            hardware_vector_call <= (next_state == eilc_pkg::EILC_CALL);
            vector_source <= next_cur_src;
            in_service <= (next_state == eilc_pkg::EILC_SERVICE);
            wake_up <= power_down && (!lvl0 || !lvl1);
        end
    end

    // =========================================================
    // Register bus
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [3:0] w_strb;
    logic wr_go;

    assign wr_go = aw_held && w_held && !s_axi_bvalid;
    assign sw_wr_ctrl = wr_go && aw_addr == eilc_pkg::CTRL_OFFSET
        && w_strb[0];
    assign events = {wake_up, ack0 || ack1, flag1, flag0};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= eilc_pkg::AXI_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= eilc_pkg::AXI_OKAY;
            type0 <= eilc_pkg::CTRL_RESET[eilc_pkg::TYPE0_BIT];
            type1 <= eilc_pkg::CTRL_RESET[eilc_pkg::TYPE1_BIT];
            prio0 <= 1'b0;
            prio1 <= 1'b0;
            mask <= eilc_pkg::EV_RESET;
            status <= eilc_pkg::EV_RESET;
            irq <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            // Set wins over write-one-to-clear.
            status <= status | events;
            if (wr_go)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= eilc_pkg::AXI_OKAY;
                if (aw_addr == eilc_pkg::CTRL_OFFSET)
                begin
                    if (w_strb[0])
                    begin
                        type0 <= w_data[eilc_pkg::TYPE0_BIT];
                        type1 <= w_data[eilc_pkg::TYPE1_BIT];
                    end
                    if (w_strb[1])
                    begin
                        prio0 <= w_data[8];
                        prio1 <= w_data[9];
                    end
                end
                else if (aw_addr == eilc_pkg::IRQ_STATUS_OFFSET)
                begin
                    if (w_strb[0])
                    begin
                        status <= (status & ~w_data[3:0]) | events;
                    end
                end
                else if (aw_addr == eilc_pkg::IRQ_MASK_OFFSET)
                begin
                    if (w_strb[0])
                    begin
                        mask <= w_data[3:0];
                    end
                end
                else if (aw_addr != eilc_pkg::CORE_STATUS_OFFSET)
                begin
                    s_axi_bresp <= eilc_pkg::AXI_SLVERR;
                end
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
            irq <= |((status | events) & mask);
            s_axi_awready <= !(s_axi_awvalid && s_axi_awready) && !aw_held
                && !(s_axi_bvalid && !s_axi_bready);
            s_axi_wready <= !(s_axi_wvalid && s_axi_wready) && !w_held
                && !(s_axi_bvalid && !s_axi_bready);
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= eilc_pkg::AXI_OKAY;
                s_axi_rdata <= 32'h0;
                if (s_axi_araddr == eilc_pkg::CTRL_OFFSET)
                begin
                    s_axi_rdata <= {22'h0, prio1, prio0, 4'h0, flag1, type1,
                        flag0, type0};
                end
                else if (s_axi_araddr == eilc_pkg::IRQ_STATUS_OFFSET)
                begin
                    s_axi_rdata <= {28'h0, status};
                end
                else if (s_axi_araddr == eilc_pkg::IRQ_MASK_OFFSET)
                begin
                    s_axi_rdata <= {28'h0, mask};
                end
                else if (s_axi_araddr == eilc_pkg::CORE_STATUS_OFFSET)
                begin
                    s_axi_rdata <= {29'h0, cur_src, state};
                end
                else
                begin
                    s_axi_rresp <= eilc_pkg::AXI_SLVERR;
                end
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // =========================================================
    // Checks
    call_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(hardware_vector_call) |-> hardware_vector_call[*4]
        ##1 !hardware_vector_call)
        else $error("vector call not four cycles");
    call_cond_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(hardware_vector_call) |-> $past(last_cycle)
        && !$past(protected_instr))
        else $error("call taken while blocked");
    edge_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        type0 && $fell(lvl0) && $stable(type0) |=> flag0)
        else $error("edge flag not set");
    level_mirror_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !type0 && !$past(type0) |-> flag0 == !$past(lvl0))
        else $error("level flag not mirroring");
    edge_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ack1 && type1 && !(lvl1 == 1'b0 && $past(lvl1)) |=> !flag1)
        else $error("edge flag not cleared on vector");
    level_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ack0 && !type0 && !lvl0 |=> flag0)
        else $error("level flag cleared on vector");
    response_a: assert property (@(posedge aclk) disable iff (!aresetn)
        take |=> ##4 in_service)
        else $error("service not reached in time");
    wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
        power_down && !lvl1 |=> wake_up)
        else $error("no wake-up");
    call_c: cover property (@(posedge aclk) take && !pick);
    nest_c: cover property (@(posedge aclk) take && in_service);
    rewake_c: cover property (@(posedge aclk) return_from_interrupt ##1 take);
endmodule

// File: tb/eilc_core_model.sv
// Model of the core: instruction ends and service routine length.
`timescale 1ns/1ps
module eilc_core_model
#(
    parameter int SVC_CYCLES = 6
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic hold,
    input wire logic in_service,
    output logic last_cycle,
    output logic return_from_interrupt
);
    // ========================================================
    // Instruction end and service end
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic next_ret;
    // A held core never reaches an instruction end, so no call is taken.
    assign last_cycle = !hold;
    always_comb
    begin
        next_cnt = 8'h00;
        next_ret = 1'b0;
        if (in_service && !return_from_interrupt)
        begin
            next_cnt = cnt + 8'h01;
            next_ret = (cnt == 8'(SVC_CYCLES - 1));
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt <= 8'h00;
            return_from_interrupt <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            return_from_interrupt <= next_ret;
        end
    end
endmodule

// File: tb/ext_interrupt_latency_ctrl_bench.sv
// Self-checking bench for the external interrupt controller.
`timescale 1ns/1ps
module ext_interrupt_latency_ctrl_bench;
    // ========================================================
    // Signals
    typedef struct packed
    {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } eilc_row_t;
    localparam logic [7:0] CT = eilc_pkg::CTRL_OFFSET;
    localparam logic [7:0] ST = eilc_pkg::IRQ_STATUS_OFFSET;
    localparam logic [7:0] MK = eilc_pkg::IRQ_MASK_OFFSET;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ext_irq0_pin_n = 1'b1;
    logic ext_irq1_pin_n = 1'b1;
    logic hold = 1'b1;
    logic protected_instr = 1'b0;
    logic power_down = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rd;
    logic last_cycle, return_from_interrupt, hardware_vector_call;
    logic vector_source, in_service, wake_up, irq, call_d;
    int fails = 0;
    int n_checks = 0;
    int n_calls = 0;
    int lat, c;
    eilc_row_t rows [6] = '{
        '{CT, 32'h5, 32'h5}, '{CT, 32'hf, 32'hf}, '{CT, 32'h305, 32'h305},
        '{CT, 32'ha, 32'h0}, '{MK, 32'hf, 32'hf}, '{MK, 32'h0, 32'h0}};
    initial
    begin
        forever #10 aclk = ~aclk;
    end
    eilc_top dut
    (
        .aclk, .aresetn, .ext_irq0_pin_n, .ext_irq1_pin_n, .last_cycle,
        .protected_instr, .return_from_interrupt, .power_down,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .hardware_vector_call, .vector_source, .in_service,
        .wake_up, .irq
    );
    eilc_core_model #(.SVC_CYCLES(6)) core
    (
        .aclk, .aresetn, .hold, .in_service, .last_cycle,
        .return_from_interrupt
    );
    always @(posedge aclk)
    begin
        if (hardware_vector_call === 1'b1 && call_d !== 1'b1)
            n_calls++;
        call_d <= hardware_vector_call;
    end
    // ========================================================
    // Tasks
    task automatic print_verdict();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic tmo();
        fails++;
        print_verdict();
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        tb = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int i = 0; i < 40 && !tb; i++)
        begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        if (!tb) tmo();
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic ta, tr;
        tr = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int i = 0; i < 40 && !tr; i++)
        begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        if (!tr) tmo();
        check(rd, e);
    endtask
    task automatic wait_for(input int which, output int n);
        n = 0;
        while ((which == 0 ? hardware_vector_call : wake_up) !== 1'b1)
        begin
            @(posedge aclk);
            #1;
            n++;
            if (n > 60) tmo();
        end
    endtask
    task automatic run_call(input logic src);
        int len;
        wait_for(0, lat);
        len = 0;
        while (hardware_vector_call === 1'b1 && len < 10)
        begin
            @(posedge aclk);
            #1;
            len++;
        end
        check(len, 4);
        check(32'(in_service), 32'h1);
        check(32'(vector_source), 32'(src));
    endtask
    task automatic idle();
        for (int i = 0; in_service !== 1'b0; i++)
        begin
            @(posedge aclk);
            if (i > 60) tmo();
        end
        repeat (10) @(posedge aclk);
    endtask
    // ========================================================
    // Main sequence
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1;
        check(32'({hardware_vector_call, in_service, wake_up, irq}), 0);
        rchk(CT, 32'h0);
        rchk(ST, 32'h0);
        rchk(MK, 32'h0);
        foreach (rows[i])
        begin
            axi_write(rows[i].a, rows[i].d);
            check(32'(rsp), 32'(eilc_pkg::AXI_OKAY));
            rchk(rows[i].a, rows[i].e);
        end
        axi_write(8'h40, 32'h1);
        check(32'(rsp), 32'(eilc_pkg::AXI_SLVERR));
        rchk(8'h44, 32'h0);
        check(32'(rsp), 32'(eilc_pkg::AXI_SLVERR));
        // Edge request: latency, call length and automatic clear.
        axi_write(CT, 32'h5);
        axi_write(ST, 32'hf);
        hold <= 1'b0;
        ext_irq0_pin_n <= 1'b0;
        #1;
        run_call(1'b0);
        check(32'(lat + 4 >= 5 && lat + 4 <= 16), 32'h1);
        rchk(CT, 32'h5);
        idle();
        ext_irq0_pin_n <= 1'b1;
        rchk(ST, 32'h5);
        axi_write(MK, 32'h4);
        repeat (2) @(posedge aclk);
        check(32'(irq), 32'h1);
        axi_write(ST, 32'h4);
        repeat (2) @(posedge aclk);
        check(32'(irq), 32'h0);
        // Blocked call: no instruction end, then a protected instruction.
        hold <= 1'b1;
        ext_irq1_pin_n <= 1'b0;
        c = n_calls;
        repeat (20) @(posedge aclk);
        rchk(CT, 32'hd);
        hold <= 1'b0;
        protected_instr <= 1'b1;
        repeat (20) @(posedge aclk);
        check(n_calls, c);
        protected_instr <= 1'b0;
        run_call(1'b1);
        idle();
        ext_irq1_pin_n <= 1'b1;
        // Level request: held through service, then requested again.
        hold <= 1'b1;
        axi_write(CT, 32'h4);
        ext_irq0_pin_n <= 1'b0;
        repeat (8) @(posedge aclk);
        rchk(CT, 32'h6);
        hold <= 1'b0;
        run_call(1'b0);
        rchk(CT, 32'h6);
        check(32'(in_service), 32'h1);
        run_call(1'b0);
        ext_irq0_pin_n <= 1'b1;
        idle();
        rchk(CT, 32'h4);
        // A level request that goes away while blocked is forgotten.
        hold <= 1'b1;
        ext_irq0_pin_n <= 1'b0;
        repeat (10) @(posedge aclk);
        ext_irq0_pin_n <= 1'b1;
        repeat (10) @(posedge aclk);
        c = n_calls;
        hold <= 1'b0;
        repeat (20) @(posedge aclk);
        check(n_calls, c);
        // Wake from power-down by a pin.
        hold <= 1'b1;
        power_down <= 1'b1;
        ext_irq1_pin_n <= 1'b0;
        wait_for(1, lat);
        check(32'(wake_up), 32'h1);
        rchk(ST, 32'hf);
        power_down <= 1'b0;
        ext_irq1_pin_n <= 1'b1;
        // Reset in mid-run: outputs and registers return to zero.
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1;
        check(32'({hardware_vector_call, in_service, wake_up, irq}), 0);
        rchk(CT, 32'h0);
        rchk(ST, 32'h0);
        rchk(MK, 32'h0);
        print_verdict();
    end
endmodule
